//--- inc/ido_cfg.svh
// Constants for the increment, decrement, OR and branch execution block.
`ifndef IDO_CFG_SVH
`define IDO_CFG_SVH
`define IDO_OPC_CLEAR_WORKING_REG_OP 14'h0100
`define IDO_OPC_MASK_CLEAR_WORKING_REG_OP 14'h3F80
`define IDO_OPC_DEC 6'h03
`define IDO_OPC_DECSZ 6'h0B
`define IDO_OPC_INCSZ 6'h0F
`define IDO_OPC_INC 6'h0A
`define IDO_OPC_IORF 6'h04
`define IDO_OPC_IORL 6'h38
`define IDO_OPC_BRANCH 3'h5
`define IDO_OPC_IORL4 4'hE
`define IDO_HI4_LSB 10
`define IDO_HI6_MSB 13
`define IDO_HI6_LSB 8
`define IDO_HI3_LSB 11
`define IDO_DEST_BIT 7
`define IDO_FADDR_MSB 6
`define IDO_LIT8_MSB 7
`define IDO_LIT11_MSB 10
`define IDO_PAGE_MSB 4
`define IDO_PAGE_LSB 3
`define IDO_ONE8 8'h01
`define IDO_ZERO8 8'h00
`define IDO_PC_RST 13'h0000
`define IDO_W_RST 8'h00
`endif

//--- inc/ido_pkg.sv
// Types for the increment, decrement, OR and branch execution block.
package ido_pkg;
    typedef enum logic [2:0] {
        IDO_RUN = 3'h1,
        IDO_FLUSH = 3'h2,
        IDO_HOLD = 3'h4
    } ido_state_type;

    typedef struct packed {
        logic [7:0] data;
        logic [6:0] addr;
        logic we;
    } ido_file_wr_type;

    typedef struct packed {
        logic zeroWe;
        logic zeroVal;
    } ido_flag_type;
endpackage

//--- core/ido_alu.sv
// Result and zero detection for the executed instruction.
`timescale 1ns/1ps
`include "ido_cfg.svh"
module ido_alu (
    // Operands.
    input wire logic [7:0] fileData,
    input wire logic [7:0] wData,
    input wire logic [7:0] lit,
    // Operation select.
    input wire logic selDec,
    input wire logic selInc,
    input wire logic selOrFile,
    input wire logic selOrLit,
    // Result.
    output logic [7:0] result,
    output logic isZero
);
    always_comb begin
        result = `IDO_ZERO8;
        if (selDec) begin
            result = fileData - `IDO_ONE8; // RQ12
        end else if (selInc) begin
            result = fileData + `IDO_ONE8; // RQ12
        end else if (selOrFile) begin
            result = wData | fileData; // RQ10
        end else if (selOrLit) begin
            result = wData | lit; // RQ9
        end
        isZero = (result == `IDO_ZERO8); // RQ11
    end
endmodule

//--- core/ido_exec.sv
// Execution unit for clear-W, increment, decrement, OR and branch instructions.
// Summary of operation
// RQ1: Clear working register loads zero into W and sets the zero flag.
// RQ2: Destination bit 0 writes W, destination bit 1 writes the file register.
// RQ3: File register address is a 7-bit field spanning 0 to 127.
// RQ4: Decrement subtracts one, routes by destination, updates only zero flag.
// RQ5: Decrement-and-skip keeps flags; zero result flushes next instruction, two cycles.
// RQ6: Increment-and-skip keeps flags; zero result flushes next instruction, two cycles.
// RQ7: Increment adds one, routes by destination, updates only zero flag.
// RQ8: Branch loads 11-bit literal and page latch bits 4:3; takes two cycles.
// RQ9: OR literal ORs W with 8-bit literal into W, updates zero flag.
// RQ10: OR file ORs W with register, routes by destination, updates zero flag.
// RQ11: Zero flag is set for a zero 8-bit result and cleared otherwise.
// RQ12: Increment and decrement wrap modulo 256 with no carry change.
`timescale 1ns/1ps
`include "ido_cfg.svh"
module ido_exec (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic nrst,
    // Instruction from fetch.
    input wire logic instrValid,
    input wire logic [13:0] instr,
    // Register file read side and page latch.
    input wire logic [7:0] fileRdData,
    input wire logic [7:0] pcPageLatch,
    // Register file read address.
    output logic [6:0] fileRdAddr,
    // Register file write.
    output ido_pkg::ido_file_wr_type fileWr,
    // Zero flag update.
    output ido_pkg::ido_flag_type zeroFlag,
    // Working register and program counter.
    output logic [7:0] wReg,
    output logic [12:0] pcLoad,
    output logic pcLoadEn,
    // Fetch control.
    output logic flushNext,
    output logic busy
);
    ido_pkg::ido_state_type state_q;
    ido_pkg::ido_state_type state_d;
    logic [7:0] w_q;
    logic [7:0] result;
    logic isZero;
    logic [5:0] hi6;
    logic isClrw;
    logic isDec;
    logic isDecSz;
    logic isInc;
    logic isIncSz;
    logic isOrFile;
    logic isOrLit;
    logic isBranch;
    logic exec;
    logic toFile;
    logic writesResult;
    logic skip;
    ido_pkg::ido_file_wr_type fileWr_q;
    ido_pkg::ido_flag_type zeroFlag_q;
    logic [12:0] pcLoad_q;
    logic pcLoadEn_q;
    logic fileWrEn;
    logic wWrEn;
    logic flagWe;

    assign hi6 = instr[`IDO_HI6_MSB:`IDO_HI6_LSB];
    assign exec = instrValid && (state_q == ido_pkg::IDO_RUN);

    // Anything that matches none of the forms below runs as a no-operation.
    always_comb begin
        isClrw = 1'b0;
        isDec = 1'b0;
        isDecSz = 1'b0;
        isInc = 1'b0;
        isIncSz = 1'b0;
        isOrFile = 1'b0;
        isOrLit = 1'b0;
        isBranch = 1'b0;
        if (exec) begin
            case (hi6)
                `IDO_OPC_DEC: begin
                    isDec = 1'b1; // RQ4
                end
                `IDO_OPC_DECSZ: begin
                    isDecSz = 1'b1; // RQ5
                end
                `IDO_OPC_INC: begin
                    isInc = 1'b1; // RQ7
                end
                `IDO_OPC_INCSZ: begin
                    isIncSz = 1'b1; // RQ6
                end
                `IDO_OPC_IORF: begin
                    isOrFile = 1'b1; // RQ10
                end
                default: begin
                    isDec = 1'b0;
                end
            endcase
            if ((instr & `IDO_OPC_MASK_CLEAR_WORKING_REG_OP) == `IDO_OPC_CLEAR_WORKING_REG_OP) begin
                isClrw = 1'b1; // RQ1
            end
            if (instr[`IDO_HI6_MSB:`IDO_HI4_LSB] == `IDO_OPC_IORL4) begin
                isOrLit = 1'b1; // RQ9
            end
            if (instr[`IDO_HI6_MSB:`IDO_HI3_LSB] == `IDO_OPC_BRANCH) begin
                isBranch = 1'b1; // RQ8
            end
        end
    end

    assign fileRdAddr = instr[`IDO_FADDR_MSB:0]; // RQ3
    assign toFile = instr[`IDO_DEST_BIT]; // RQ2
    assign writesResult = isDec || isDecSz || isInc || isIncSz || isOrFile;
    assign skip = (isDecSz || isIncSz) && isZero; // RQ5 RQ6
    assign fileWrEn = writesResult && toFile; // RQ2
    assign wWrEn = isOrLit || (writesResult && !toFile); // RQ2 RQ9
    assign flagWe = isClrw || isDec || isInc || isOrLit || isOrFile; // RQ4 RQ7

    ido_alu alu (
        .fileData(fileRdData),
        .wData(w_q),
        .lit(instr[`IDO_LIT8_MSB:0]),
        .selDec(isDec || isDecSz),
        .selInc(isInc || isIncSz),
        .selOrFile(isOrFile),
        .selOrLit(isOrLit),
        .result(result),
        .isZero(isZero)
    );

    // Flush and branch each cost one extra instruction cycle in which fetch is discarded.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ido_pkg::IDO_RUN: begin
                if (skip) begin
                    state_d = ido_pkg::IDO_FLUSH; // RQ5 RQ6
                end else if (isBranch) begin
                    state_d = ido_pkg::IDO_HOLD; // RQ8
                end
            end
            ido_pkg::IDO_FLUSH: begin
                state_d = ido_pkg::IDO_RUN; // RQ5 RQ6
            end
            ido_pkg::IDO_HOLD: begin
                state_d = ido_pkg::IDO_RUN; // RQ8
            end
            // An illegal state code falls back to run, so a disturbance costs one cycle at most.
            default: begin
                state_d = ido_pkg::IDO_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ido_pkg::IDO_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            w_q <= `IDO_W_RST;
        end else if (isClrw) begin
            w_q <= `IDO_ZERO8; // RQ1
        end else if (wWrEn) begin
            w_q <= result; // RQ2 RQ9
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fileWr_q <= '0;
        end else begin
            fileWr_q.we <= fileWrEn; // RQ2
            // Address and data only move on a write, so the register file sees a quiet bus.
            if (fileWrEn) begin
                fileWr_q.addr <= instr[`IDO_FADDR_MSB:0]; // RQ3
                fileWr_q.data <= result;
            end
        end
    end

    // Skip forms leave the zero flag alone, so only clear, OR and the plain increment and decrement forms raise the write enable.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            zeroFlag_q <= '0;
        end else begin
            zeroFlag_q.zeroWe <= flagWe; // RQ4 RQ7
            if (flagWe) begin
                zeroFlag_q.zeroVal <= isClrw ? 1'b1 : isZero; // RQ1 RQ11
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pcLoadEn_q <= 1'b0;
        end else begin
            pcLoadEn_q <= isBranch; // RQ8
        end
    end

    // The target holds after the pulse, so fetch may pick it up a cycle late if it must.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pcLoad_q <= `IDO_PC_RST;
        end else if (isBranch) begin
            pcLoad_q <= {pcPageLatch[`IDO_PAGE_MSB:`IDO_PAGE_LSB],
                         instr[`IDO_LIT11_MSB:0]}; // RQ8
        end
    end

    assign wReg = w_q;
    assign fileWr = fileWr_q;
    assign zeroFlag = zeroFlag_q;
    assign pcLoad = pcLoad_q;
    assign pcLoadEn = pcLoadEn_q;
    assign flushNext = skip || isBranch;
    assign busy = (state_q != ido_pkg::IDO_RUN);
endmodule

//--- test/ido_exec_sva.sv
// Port assertions for the execution unit.
`timescale 1ns/1ps
module ido_exec_sva (
    // Inputs.
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic instrValid,
    input wire logic [13:0] instr,
    input wire logic [7:0] fileRdData,
    input wire logic [7:0] pcPageLatch,
    // Outputs.
    input wire logic [6:0] fileRdAddr,
    input wire ido_pkg::ido_file_wr_type fileWr,
    input wire ido_pkg::ido_flag_type zeroFlag,
    input wire logic [7:0] wReg,
    input wire logic [12:0] pcLoad,
    input wire logic pcLoadEn,
    input wire logic flushNext,
    input wire logic busy
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic tk;
    assign tk = instrValid && !busy;
    a_clear_w: assert property (tk && instr == 14'h0100 |=> wReg == 8'h00 && zeroFlag == 2'h3)
        else $error("bad clear");
    a_addr_field: assert property (fileRdAddr == instr[6:0])
        else $error("bad address");
    a_dec_file: assert property (tk && instr[13:7] == 7'h07 |=> fileWr.we &&
        fileWr.data == $past(fileRdData) - 8'h01 && fileWr.addr == $past(instr[6:0]))
        else $error("bad decrement");
    a_inc_w: assert property (tk && instr[13:7] == 7'h14 |=> wReg == $past(fileRdData) + 8'h01
        && !fileWr.we && zeroFlag.zeroWe) else $error("bad increment");
    a_decsz_skip: assert property (tk && instr[13:8] == 6'h0B |->
        flushNext == (fileRdData == 8'h01) ##1 !zeroFlag.zeroWe) else $error("bad dec skip");
    a_incsz_skip: assert property (tk && instr[13:8] == 6'h0F |->
        flushNext == (fileRdData == 8'hFF) ##1 !zeroFlag.zeroWe) else $error("bad inc skip");
    a_branch_pc: assert property (tk && instr[13:11] == 3'h5 |-> flushNext ##1 pcLoadEn && busy
        && pcLoad == {$past(pcPageLatch[4:3]), $past(instr[10:0])}) else $error("bad branch");
    a_or_lit: assert property (tk && instr[13:10] == 4'hE |=> zeroFlag.zeroVal == (wReg == 8'h00)
        && wReg == ($past(wReg) | $past(instr[7:0]))) else $error("bad or literal");
    a_or_file: assert property (tk && instr[13:7] == 7'h09 |=> fileWr.we
        && fileWr.data == ($past(wReg) | $past(fileRdData))
        && zeroFlag.zeroWe && zeroFlag.zeroVal == (fileWr.data == 8'h00))
        else $error("bad or file");
endmodule
bind ido_exec ido_exec_sva u_sva (
    .core_clk(core_clk),
    .nrst(nrst),
    .instrValid(instrValid),
    .instr(instr),
    .fileRdData(fileRdData),
    .pcPageLatch(pcPageLatch),
    .fileRdAddr(fileRdAddr),
    .fileWr(fileWr),
    .zeroFlag(zeroFlag),
    .wReg(wReg),
    .pcLoad(pcLoad),
    .pcLoadEn(pcLoadEn),
    .flushNext(flushNext),
    .busy(busy)
);

//--- test/tb_top.sv
// Directed bench for the execution unit.
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic instrValid = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic [7:0] fileRdData = 8'h00;
    logic [7:0] pcPageLatch = 8'hE8;
    logic [6:0] fileRdAddr;
    ido_pkg::ido_file_wr_type fileWr;
    ido_pkg::ido_flag_type zeroFlag;
    logic [7:0] wReg;
    logic [12:0] pcLoad;
    logic pcLoadEn, flushNext, busy, fl;
    int n_mismatch = 0;
    int num_checks = 0;
    ido_exec DUT (
        .core_clk(core_clk),
        .nrst(nrst),
        .instrValid(instrValid),
        .instr(instr),
        .fileRdData(fileRdData),
        .pcPageLatch(pcPageLatch),
        .fileRdAddr(fileRdAddr),
        .fileWr(fileWr),
        .zeroFlag(zeroFlag),
        .wReg(wReg),
        .pcLoad(pcLoad),
        .pcLoadEn(pcLoadEn),
        .flushNext(flushNext),
        .busy(busy)
    );
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // Valid is left high so back-to-back issues never touch it twice in one step.
    task automatic ex(input logic [13:0] i, input logic [7:0] f);
        instr = i;
        fileRdData = f;
        instrValid = 1'b1;
        #1 fl = flushNext;
        @(negedge core_clk);
    endtask
    task automatic t_wreg;
        ex(14'h38A5, 8'h00);
        chk({wReg, zeroFlag}, {8'hA5, 2'h2});
        ex(14'h0100, 8'h00);
        chk({wReg, zeroFlag, fileWr.we}, {8'h00, 2'h3, 1'b0});
        ex(14'h3800, 8'h00);
        chk({wReg, zeroFlag}, {8'h00, 2'h3});
        ex(14'h0433, 8'h3C);
        chk({wReg, fileWr.we, fileRdAddr}, {8'h3C, 1'b0, 7'h33});
        ex(14'h04FF, 8'h40);
        chk({wReg, fileWr, zeroFlag}, {8'h3C, 8'h7C, 7'h7F, 1'b1, 2'h2});
        $display("or and clear test done");
    endtask
    task automatic t_incdec;
        ex(14'h0A85, 8'hFF);
        chk({fileWr, zeroFlag}, {8'h00, 7'h05, 1'b1, 2'h3});
        ex(14'h0390, 8'h01);
        chk({wReg, fileWr, zeroFlag}, {8'h3C, 8'h00, 7'h10, 1'b1, 2'h3});
        ex(14'h0A10, 8'h7F);
        chk({wReg, fileWr.we, zeroFlag}, {8'h80, 1'b0, 2'h2});
        ex(14'h0301, 8'h00);
        chk({wReg, fileWr.we, zeroFlag}, {8'hFF, 1'b0, 2'h2});
        $display("increment decrement test done");
    endtask
    task automatic t_skip;
        ex(14'h0B82, 8'h01);
        chk({fl, fileWr, zeroFlag.zeroWe, busy}, {1'b1, 8'h00, 7'h02, 1'b1, 1'b0, 1'b1});
        ex(14'h0100, 8'h00);
        chk({wReg, zeroFlag.zeroWe, busy}, {8'hFF, 2'h0});
        ex(14'h0F05, 8'h05);
        chk({fl, wReg, zeroFlag.zeroWe}, {1'b0, 8'h06, 1'b0});
        ex(14'h0F05, 8'hFF);
        chk({fl, wReg, busy}, {1'b1, 8'h00, 1'b1});
        instrValid = 1'b0;
        @(negedge core_clk);
        $display("skip test done");
    endtask
    task automatic t_branch;
        ex(14'h2D55, 8'h00);
        chk({fl, pcLoadEn, busy, pcLoad}, {3'h7, 13'h0D55});
        instrValid = 1'b0;
        @(negedge core_clk);
        chk({pcLoadEn, busy, pcLoad}, {2'h0, 13'h0D55});
        pcPageLatch = 8'h10;
        ex(14'h2FFF, 8'h00);
        chk({fl, pcLoadEn, busy, pcLoad}, {3'h7, 13'h17FF});
        instrValid = 1'b0;
        @(negedge core_clk);
        $display("branch test done");
    endtask
    task automatic t_reset;
        ex(14'h2A00, 8'h00);
        chk({busy, pcLoadEn, pcLoad}, {2'h3, 13'h1200});
        nrst = 1'b0;
        instrValid = 1'b0;
        #1 chk({wReg, pcLoad, pcLoadEn, busy, fileWr.we, zeroFlag}, 32'h0);
        @(negedge core_clk);
        nrst = 1'b1;
        ex(14'h3812, 8'h00);
        chk({wReg, zeroFlag, busy}, {8'h12, 2'h2, 1'b0});
        $display("reset test done");
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        results;
    end
    initial begin
        repeat (16) @(negedge core_clk);
        nrst = 1'b1;
        chk({wReg, pcLoad, busy}, 24'h0);
        t_wreg;
        t_incdec;
        t_skip;
        t_branch;
        t_reset;
        results;
    end
endmodule
